// ===== verilog/sfr_pkg.sv
// Package: offsets, field positions and reset values of the special register bank
package sfr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_INDIRECT_DATA = 5'h00;  // Indirect data port (no storage)
  localparam logic [4:0] OFS_STATUS        = 5'h03;  // Status (bank select bits only here)
  localparam logic [4:0] OFS_INDIRECT_PTR  = 5'h04;
  localparam logic [4:0] OFS_PORT_A        = 5'h05;
  localparam logic [4:0] OFS_PORT_B        = 5'h06;
  localparam logic [4:0] OFS_POWER         = 5'h08;
  localparam logic [4:0] OFS_WAKEUP        = 5'h09;
  localparam logic [4:0] OFS_PC_HIGH       = 5'h0A;
  localparam logic [4:0] OFS_PULL_LOW      = 5'h0B;
  localparam logic [4:0] OFS_PULL_HIGH     = 5'h0C;
  localparam logic [4:0] OFS_INT_ENABLE    = 5'h0E;
  localparam logic [4:0] OFS_INT_FLAGS     = 5'h0F;
  localparam logic [4:0] OFS_DIRECTION     = 5'h10;  // Port A direction; port B direction at OFS_DIRECTION_B
  localparam logic [4:0] OFS_DIRECTION_B   = 5'h11;

  // ----------------------------------------------------------------
  // Reset values and implemented masks
  // ----------------------------------------------------------------
  localparam logic [7:0] POWER_RESET     = 8'h88;
  localparam logic [7:0] WAKEUP_RESET    = 8'h3F;
  localparam logic [7:0] PULL_LOW_RESET  = 8'hFF;
  localparam logic [7:0] PULL_HIGH_RESET = 8'h3F;
  localparam logic [7:0] SIX_BIT_MASK    = 8'h3F;  // Wake-up and pull-high bits
  localparam logic [7:0] INT_MASK        = 8'hDF;  // Bit 5 of enable/flags absent
  localparam logic [7:0] PC_HIGH_MASK    = 8'h07;
  localparam logic [7:0] PORT_B_PIN_MASK = 8'h3F;  // Bits 7..6 carry no pins
  localparam logic [7:0] DIR_RESET       = 8'hFF;  // All pins input after reset

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_CMP_EN   = 2;
  localparam int POS_LVR_EN   = 3;
  localparam int POS_LVD_EN   = 5;
  localparam int POS_WDT_EN   = 7;
  localparam int POS_CRYSTAL_SPEEDUP_STOP = 6;
  localparam int POS_BANK_LO  = 6;
  localparam int POS_PORT_CHG = 1;  // Port change flag position
endpackage : sfr_pkg

// ===== verilog/bank_memory.sv
// Data memory: four banks of 128 bytes, registered read data
module bank_memory (
  // Clock
  input  wire logic       ref_clk,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [8:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [8:0] rd_addr,
  output logic      [7:0] rd_data
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [512];  // Contents undefined after power-up

  // Write and registered read; no reset so it maps onto a RAM
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // bank_memory

// ===== verilog/mcu_port_power_irq_regs.sv
// Special register bank: pointer, ports, power, pulls, interrupt enables and flags
module mcu_port_power_irq_regs #(
  parameter bit READ_SOURCE_OPTION = 1'b0  // 1: output pins read their latch
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Port pins
  input  wire logic [7:0] port_a_in,
  input  wire logic [5:0] port_b_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  output logic      [5:0] port_b_out,
  output logic      [5:0] port_b_oe,
  // Power and analog enables
  output logic            comparator_enable,
  output logic            low_voltage_reset_enable,
  output logic            low_voltage_detect_enable,
  output logic            watchdog_enable,
  output logic            crystal_speedup_stop,
  // Wake-up and resistor controls
  output logic      [5:0] pin_wakeup_enable,
  output logic      [3:0] port_a_pull_low_off,
  output logic      [3:0] port_b_pull_low_off,
  output logic      [5:0] port_b_pull_high_off,
  // Program counter high bits
  output logic      [2:0] pc_high_bits,
  // Interrupt events, one-cycle pulses from same-clock logic
  input  wire logic       timer0_overflow_evt,
  input  wire logic       ext_irq0_evt,
  input  wire logic       timer1_underflow_evt,
  input  wire logic       low_voltage_evt,
  input  wire logic       watchdog_timeout_evt,
  input  wire logic       ext_irq1_evt,
  input  wire logic [7:0] port_a_change_en,  // Pins taking part in change detection
  input  wire logic [5:0] port_b_change_en,
  // Pending interrupt request to the core
  output logic            irq_pending
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] indirect_pointer_q;          // Pointer and spare bit 7
  logic [1:0] bank_select_q;               // Status bits 7..6
  logic [7:0] port_a_latch_q;              // Port A output latch
  logic [7:0] port_b_latch_q;              // Port B latch, bits 7..6 storage
  logic [7:0] power_control_q;
  logic [7:0] wakeup_q;
  logic [2:0] pc_high_q;
  logic       speedup_stop_q;              // Sticky once set until reset
  logic [7:0] pull_low_q;
  logic [7:0] pull_high_q;
  logic [7:0] int_enable_q;
  logic [7:0] int_flags_q;
  logic [7:0] int_flags_d;
  logic [7:0] dir_a_q;                     // 1 = input
  logic [5:0] dir_b_q;
  logic [7:0] reg_rdata_q;
  logic       irq_q;
  // Pin synchronisers
  logic [7:0] pa_meta_q, pa_sync_q, pa_prev_q;
  logic [5:0] pb_meta_q, pb_sync_q, pb_prev_q;
  // Indirect access
  logic       ind_wr, ind_rd_q;
  logic [8:0] ind_addr;
  logic [7:0] mem_rdata;
  logic [7:0] direct_rdata;
  logic       port_change;
  logic [7:0] events;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Two stages before any use; previous sample feeds change detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pa_meta_q <= 8'h00;
      pa_sync_q <= 8'h00;
      pa_prev_q <= 8'h00;
      pb_meta_q <= 6'h00;
      pb_sync_q <= 6'h00;
      pb_prev_q <= 6'h00;
    end else begin
      pa_meta_q <= port_a_in;
      pa_sync_q <= pa_meta_q;
      pa_prev_q <= pa_sync_q;
      pb_meta_q <= port_b_in;
      pb_sync_q <= pb_meta_q;
      pb_prev_q <= pb_sync_q;
    end
  end

  // Change on any participating pin
  assign port_change = |(((pa_sync_q ^ pa_prev_q) & port_a_change_en)) |
                       |(((pb_sync_q ^ pb_prev_q) & port_b_change_en));

  // ----------------------------------------------------------------
  // Indirect addressing
  // ----------------------------------------------------------------
  // Bank and pointer form the data memory address
  assign ind_addr = {bank_select_q, indirect_pointer_q[6:0]};
  assign ind_wr   = reg_wr && (reg_addr == sfr_pkg::OFS_INDIRECT_DATA);

  bank_memory u_bank_memory (
    .ref_clk (ref_clk),
    .wr_en   (ind_wr),
    .wr_addr (ind_addr),
    .wr_data (reg_wdata),
    .rd_addr (ind_addr),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Pointer, status bank bits and port latches
  // ----------------------------------------------------------------
  // Pointer bit 7 is kept as plain storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      indirect_pointer_q <= 8'h00;
      bank_select_q      <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == sfr_pkg::OFS_INDIRECT_PTR) begin
        indirect_pointer_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == sfr_pkg::OFS_STATUS) begin
        bank_select_q <= reg_wdata[7:sfr_pkg::POS_BANK_LO];
      end
    end
  end

  // Latches load regardless of direction
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_latch_q <= 8'h00;
      port_b_latch_q <= 8'h00;
      dir_a_q        <= sfr_pkg::DIR_RESET;
      dir_b_q        <= sfr_pkg::DIR_RESET[5:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        sfr_pkg::OFS_PORT_A:      port_a_latch_q <= reg_wdata;
        sfr_pkg::OFS_PORT_B:      port_b_latch_q <= reg_wdata;
        sfr_pkg::OFS_DIRECTION:   dir_a_q        <= reg_wdata;
        sfr_pkg::OFS_DIRECTION_B: dir_b_q        <= reg_wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power, wake-up, PC buffer and resistor controls
  // ----------------------------------------------------------------
  // Unimplemented positions are masked on write so they read zero; power keeps all eight bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_control_q <= sfr_pkg::POWER_RESET;
      wakeup_q        <= sfr_pkg::WAKEUP_RESET;
      pc_high_q       <= 3'h0;
      pull_low_q      <= sfr_pkg::PULL_LOW_RESET;
      pull_high_q     <= sfr_pkg::PULL_HIGH_RESET;
      int_enable_q    <= 8'h00;
    end else if (reg_wr) begin
      unique case (reg_addr)
        sfr_pkg::OFS_POWER:      power_control_q <= reg_wdata;
        sfr_pkg::OFS_WAKEUP:     wakeup_q  <= reg_wdata & sfr_pkg::SIX_BIT_MASK;
        sfr_pkg::OFS_PC_HIGH:    pc_high_q <= reg_wdata[2:0];
        sfr_pkg::OFS_PULL_LOW:   pull_low_q <= reg_wdata;
        sfr_pkg::OFS_PULL_HIGH:  pull_high_q <= reg_wdata & sfr_pkg::SIX_BIT_MASK;
        sfr_pkg::OFS_INT_ENABLE: int_enable_q <= reg_wdata & sfr_pkg::INT_MASK;
        default: begin
        end
      endcase
    end
  end

  // Speed-up stop: a written one latches; a zero does nothing, since the
  // oscillator cannot restart its speed-up once stopped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      speedup_stop_q <= 1'b0;
    end else if (reg_wr && reg_addr == sfr_pkg::OFS_PC_HIGH &&
                 reg_wdata[sfr_pkg::POS_CRYSTAL_SPEEDUP_STOP]) begin
      speedup_stop_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Event vector in flag bit order; bit 5 absent
  assign events = {ext_irq1_evt, watchdog_timeout_evt, 1'b0, low_voltage_evt,
                   timer1_underflow_evt, ext_irq0_evt, port_change,
                   timer0_overflow_evt};

  // Software write replaces flags, then events are ORed on top
  always_comb begin
    int_flags_d = int_flags_q;  // Hardware never clears by itself
    if (reg_wr && reg_addr == sfr_pkg::OFS_INT_FLAGS) begin
      int_flags_d = reg_wdata;
    end
    int_flags_d = (int_flags_d | events) & sfr_pkg::INT_MASK;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_flags_q <= 8'h00;
    end else begin
      int_flags_q <= int_flags_d;
    end
  end

  // Request toward the core while any enabled flag stands
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_flags_q & int_enable_q);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; option picks latch or pin for output pins
  always_comb begin
    direct_rdata = 8'h00;  // Unmapped offsets read zero
    unique case (reg_addr)
      sfr_pkg::OFS_STATUS:       direct_rdata = {bank_select_q, 6'h00};
      sfr_pkg::OFS_INDIRECT_PTR: direct_rdata = indirect_pointer_q;
      sfr_pkg::OFS_PORT_A: begin
        direct_rdata = (dir_a_q & pa_sync_q) |
                       (~dir_a_q & (READ_SOURCE_OPTION ? port_a_latch_q : pa_sync_q));
      end
      sfr_pkg::OFS_PORT_B: begin
        direct_rdata = {port_b_latch_q[7:6],
                        (dir_b_q & pb_sync_q) |
                        (~dir_b_q & (READ_SOURCE_OPTION ? port_b_latch_q[5:0] : pb_sync_q))};
      end
      sfr_pkg::OFS_POWER:        direct_rdata = power_control_q;
      sfr_pkg::OFS_WAKEUP:       direct_rdata = wakeup_q;
      sfr_pkg::OFS_PC_HIGH:      direct_rdata = {5'h00, pc_high_q};  // Stop bit reads zero
      sfr_pkg::OFS_PULL_LOW:     direct_rdata = pull_low_q;
      sfr_pkg::OFS_PULL_HIGH:    direct_rdata = pull_high_q;
      sfr_pkg::OFS_INT_ENABLE:   direct_rdata = int_enable_q;
      sfr_pkg::OFS_INT_FLAGS:    direct_rdata = int_flags_q & int_enable_q;
      sfr_pkg::OFS_DIRECTION:    direct_rdata = dir_a_q;
      sfr_pkg::OFS_DIRECTION_B:  direct_rdata = {2'h0, dir_b_q};
      default:                   direct_rdata = 8'h00;
    endcase
  end

  // Memory already registers its read, so the indirect path skips this stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
      ind_rd_q    <= 1'b0;
    end else begin
      ind_rd_q <= reg_rd && (reg_addr == sfr_pkg::OFS_INDIRECT_DATA);
      if (reg_rd) begin
        reg_rdata_q <= direct_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Indirect read data selected after the memory register
  assign reg_rdata = ind_rd_q ? mem_rdata : reg_rdata_q;

  assign port_a_out                = port_a_latch_q;
  assign port_a_oe                 = ~dir_a_q;
  assign port_b_out                = port_b_latch_q[5:0];
  assign port_b_oe                 = ~dir_b_q;
  assign comparator_enable         = power_control_q[sfr_pkg::POS_CMP_EN];
  assign low_voltage_reset_enable  = power_control_q[sfr_pkg::POS_LVR_EN];
  assign low_voltage_detect_enable = power_control_q[sfr_pkg::POS_LVD_EN];
  assign watchdog_enable           = power_control_q[sfr_pkg::POS_WDT_EN];
  assign crystal_speedup_stop      = speedup_stop_q;
  assign pin_wakeup_enable         = wakeup_q[5:0];
  assign port_a_pull_low_off       = pull_low_q[3:0];
  assign port_b_pull_low_off       = pull_low_q[7:4];
  assign port_b_pull_high_off      = pull_high_q[5:0];
  assign pc_high_bits              = pc_high_q;
  assign irq_pending               = irq_q;
endmodule // mcu_port_power_irq_regs

// ===== bench/mcu_port_power_irq_regs_monitor.sv
// Port checker for the special register bank, bound to the top module
module mcu_port_power_irq_regs_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Control outputs
  input wire logic [7:0] port_a_out,
  input wire logic       comparator_enable,
  input wire logic       low_voltage_reset_enable,
  input wire logic       low_voltage_detect_enable,
  input wire logic       watchdog_enable,
  input wire logic       crystal_speedup_stop,
  input wire logic [5:0] pin_wakeup_enable,
  input wire logic [3:0] port_a_pull_low_off,
  input wire logic [3:0] port_b_pull_low_off,
  input wire logic [5:0] port_b_pull_high_off,
  input wire logic [2:0] pc_high_bits
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] enable_q;  // Shadow of the interrupt enables, for masked reads

  // Track enables from the write strobe alone, independent of the design
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= 8'h00;
    end else if (reg_wr && reg_addr == sfr_pkg::OFS_INT_ENABLE) begin
      enable_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_power;
    reg_wr && reg_addr == sfr_pkg::OFS_POWER |=> {watchdog_enable, low_voltage_detect_enable,
      low_voltage_reset_enable, comparator_enable} == {$past(reg_wdata[7]),
      $past(reg_wdata[5]), $past(reg_wdata[3]), $past(reg_wdata[2])};
  endproperty
  a_power: assert property (p_power) else $error("power enables differ from write");
  property p_reset_vals;
    $rose(reset_n) |-> watchdog_enable && low_voltage_reset_enable && !comparator_enable
      && !low_voltage_detect_enable && !crystal_speedup_stop;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad enables after reset");
  property p_wakeup;
    reg_wr && reg_addr == sfr_pkg::OFS_WAKEUP |=> pin_wakeup_enable == $past(reg_wdata[5:0]);
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wake-up enables differ");
  property p_pc_high;
    reg_wr && reg_addr == sfr_pkg::OFS_PC_HIGH |=> pc_high_bits == $past(reg_wdata[2:0]);
  endproperty
  a_pc_high: assert property (p_pc_high) else $error("pc high bits differ");
  property p_speedup;
    reg_wr && reg_addr == sfr_pkg::OFS_PC_HIGH && reg_wdata[6] |=> crystal_speedup_stop[*3];
  endproperty
  a_speedup: assert property (p_speedup) else $error("speed-up stop not held");
  property p_pull_low;
    reg_wr && reg_addr == sfr_pkg::OFS_PULL_LOW
      |=> {port_b_pull_low_off, port_a_pull_low_off} == $past(reg_wdata);
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("pull-low controls differ");
  property p_pull_high;
    reg_wr && reg_addr == sfr_pkg::OFS_PULL_HIGH
      |=> port_b_pull_high_off == $past(reg_wdata[5:0]);
  endproperty
  a_pull_high: assert property (p_pull_high) else $error("pull-high controls differ");
  property p_latch;
    reg_wr && reg_addr == sfr_pkg::OFS_PORT_A |=> port_a_out == $past(reg_wdata);
  endproperty
  a_latch: assert property (p_latch) else $error("port A latch not loaded");
  property p_masked;
    reg_rd && reg_addr == sfr_pkg::OFS_INT_FLAGS |=> (reg_rdata & ~$past(enable_q)) == 8'h00;
  endproperty
  a_masked: assert property (p_masked) else $error("disabled flag read as one");
  property p_unmapped;
    reg_rd && reg_addr == 5'h0D |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");
endmodule // mcu_port_power_irq_regs_monitor

bind mcu_port_power_irq_regs mcu_port_power_irq_regs_monitor u_monitor (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_out(port_a_out),
  .comparator_enable(comparator_enable), .low_voltage_reset_enable(low_voltage_reset_enable),
  .low_voltage_detect_enable(low_voltage_detect_enable), .watchdog_enable(watchdog_enable),
  .crystal_speedup_stop(crystal_speedup_stop), .pin_wakeup_enable(pin_wakeup_enable),
  .port_a_pull_low_off(port_a_pull_low_off), .port_b_pull_low_off(port_b_pull_low_off),
  .port_b_pull_high_off(port_b_pull_high_off), .pc_high_bits(pc_high_bits));

// ===== bench/mcu_port_power_irq_regs_tb_top.sv
// Self-checking bench for the special register bank
module mcu_port_power_irq_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] port_a_in = 8'h00;
  logic [5:0] port_b_in = 6'h00;
  logic [5:0] evt = 6'h00;  // {ext1, watchdog, low voltage, timer1, ext0, timer0}
  logic [7:0] a_chg = 8'h00;
  logic [5:0] b_chg = 6'h00;
  logic [7:0] reg_rdata, port_a_out, port_a_oe;
  logic [5:0] port_b_out, port_b_oe, wake, ph_b;
  logic [3:0] pl_a, pl_b;
  logic [2:0] pc_hi;
  logic       cmp_en, lvr_en, lvd_en, wdt_en, xspd, irq_pending;
  int         checks = 0;
  int         mismatches = 0;

  mcu_port_power_irq_regs DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe), .comparator_enable(cmp_en),
    .low_voltage_reset_enable(lvr_en), .low_voltage_detect_enable(lvd_en),
    .watchdog_enable(wdt_en), .crystal_speedup_stop(xspd), .pin_wakeup_enable(wake),
    .port_a_pull_low_off(pl_a), .port_b_pull_low_off(pl_b), .port_b_pull_high_off(ph_b),
    .pc_high_bits(pc_hi), .timer0_overflow_evt(evt[0]), .ext_irq0_evt(evt[1]),
    .timer1_underflow_evt(evt[2]), .low_voltage_evt(evt[3]), .watchdog_timeout_evt(evt[4]),
    .ext_irq1_evt(evt[5]), .port_a_change_en(a_chg), .port_b_change_en(b_chg),
    .irq_pending(irq_pending));

  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks; each starts just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read data is sampled in the cycle after the strobe edge; indirect data stands only then
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("register %h", a), e, v);
  endtask
  // One-cycle event pulses, the way same-clock sources give them
  task automatic pulse(input logic [5:0] m);
    evt <= m;
    @(posedge ref_clk);
    evt <= 6'h00;
    @(posedge ref_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [4:0] ra [7] = '{5'h08, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h0A};
    static logic [7:0] rv [7] = '{8'h88, 8'h3F, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00};
    static logic [4:0] wa [8] = '{5'h04, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0D};
    static logic [7:0] wd [8] = '{8'h85, 8'h55, 8'hFF, 8'hFF, 8'h5A, 8'hC0, 8'hFF, 8'hFF};
    static logic [7:0] we [8] = '{8'h85, 8'h55, 8'h3F, 8'h07, 8'h5A, 8'h00, 8'hDF, 8'h00};
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    // Reset values, then write and read back with unimplemented bits at zero
    foreach (ra[i]) rchk(ra[i], rv[i]);
    chk("port B drive", 8'h00, {2'b00, port_b_oe});
    foreach (wa[i]) begin
      wr(wa[i], wd[i]);
      rchk(wa[i], we[i]);
    end
    chk("power outputs", 8'h01, {4'h0, wdt_en, lvd_en, lvr_en, cmp_en});
    chk("wake-up", 8'h3F, {2'b00, wake});
    chk("pc high", 8'h07, {5'h00, pc_hi});
    chk("speed-up stop", 8'h01, {7'h00, xspd});
    chk("pull-low", 8'h5A, {pl_b, pl_a});
    chk("pull-high", 8'h00, {2'b00, ph_b});
    wr(sfr_pkg::OFS_POWER, 8'hAA);
    chk("power outputs", 8'h0E, {4'h0, wdt_en, lvd_en, lvr_en, cmp_en});
    // Port A as outputs, then as inputs
    wr(sfr_pkg::OFS_DIRECTION, 8'h00);
    wr(sfr_pkg::OFS_PORT_A, 8'hA5);
    chk("port A latch", 8'hA5, port_a_out);
    chk("port A drive", 8'hFF, port_a_oe);
    port_a_in <= 8'h3C;
    repeat (3) @(posedge ref_clk);
    rchk(sfr_pkg::OFS_PORT_A, 8'h3C);
    wr(sfr_pkg::OFS_DIRECTION, 8'hFF);
    port_a_in <= 8'h0F;
    repeat (3) @(posedge ref_clk);
    rchk(sfr_pkg::OFS_PORT_A, 8'h0F);
    port_b_in <= 6'h0A;
    wr(sfr_pkg::OFS_PORT_B, 8'hC5);
    chk("port B latch", 8'h05, {2'b00, port_b_out});
    rchk(sfr_pkg::OFS_PORT_B, 8'hCA);
    // Flags set while masked read zero, then show once enabled
    wr(sfr_pkg::OFS_INT_ENABLE, 8'h00);
    pulse(6'h3F);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq_pending});
    wr(sfr_pkg::OFS_INT_ENABLE, 8'hDF);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'hDD);
    chk("irq pending", 8'h01, {7'h00, irq_pending});
    wr(sfr_pkg::OFS_INT_ENABLE, 8'h01);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'h01);
    // Clear in the same cycle as a timer0 event: the event must survive
    evt <= 6'h01;
    reg_addr <= sfr_pkg::OFS_INT_FLAGS;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    evt <= 6'h00;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'h01);
    wr(sfr_pkg::OFS_INT_FLAGS, 8'h00);
    wr(sfr_pkg::OFS_INT_ENABLE, 8'hDF);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'h00);
    // Pin change on a watched pin raises the change flag
    a_chg <= 8'hFF;
    b_chg <= 6'h3F;
    repeat (2) @(posedge ref_clk);
    port_a_in <= 8'hF0;
    repeat (6) @(posedge ref_clk);
    rchk(sfr_pkg::OFS_INT_FLAGS, 8'h02);
    // Indirect access across banks; pointer bit 7 is not address
    wr(sfr_pkg::OFS_STATUS, 8'h40);
    wr(sfr_pkg::OFS_INDIRECT_PTR, 8'h12);
    wr(sfr_pkg::OFS_INDIRECT_DATA, 8'h77);
    wr(sfr_pkg::OFS_STATUS, 8'h00);
    wr(sfr_pkg::OFS_INDIRECT_DATA, 8'h11);
    rchk(sfr_pkg::OFS_INDIRECT_DATA, 8'h11);
    wr(sfr_pkg::OFS_STATUS, 8'h40);
    wr(sfr_pkg::OFS_INDIRECT_PTR, 8'h92);
    rchk(sfr_pkg::OFS_INDIRECT_DATA, 8'h77);
    rchk(sfr_pkg::OFS_INDIRECT_PTR, 8'h92);
    final_report();
  end
endmodule // mcu_port_power_irq_regs_tb_top
